// [hdl/timer2_auto_reload.sv]
// sixteen-bit auto-reload timer with split 8-bit mode
//
// Notes on behaviour
// [R1] high overflow flag sets when high byte rolls from ff to 00
// [R2] in 16-bit mode high flag sets when whole count wraps ffff to 0000
// [R3] set high flag with timer interrupt enabled raises the interrupt request
// [R4] hardware never clears high flag; only a software write of zero
// [R5] low flag sets on every low byte wrap in both modes, never auto-cleared
// [R6] low flag interrupts only when low irq enable and timer irq enable set
// [R7] software keeps low irq enable cleared in 16-bit mode
// [R8] split select: zero one 16-bit counter, one two 8-bit counters
// [R9] run control zero stops counting, one lets it count
// [R10] in split mode run gates only high byte; low byte always counts
// [R11] alternate select: zero system clock over 12, one external over 8
// [R12] external divided timebase synchronised to system clock before use
// [R13] in split mode alternate select serves both bytes, fast selects override
// [R14] control bits 4 and 1 read zero, writes ignored
// [R15] two writable 8-bit reload registers hold reload low and high bytes
// [R16] count bytes form one 16-bit count, or two 8-bit counts in split
// [R17] 16-bit wrap loads both reload bytes into the count
// [R18] split wrap reloads each byte from its own reload byte
// [R19] fast select one uses system clock, zero the alternate timebase
// [R20] count advances one per cycle with enable pulse while permitted
// [R21] reset clears control, reload and count; stopped, 16-bit, low irq off
`timescale 1ns/10ps
`include "timer2_defs.svh"
module timer2_auto_reload #(
  parameter int SYS_DIV = `T2_SYS_DIV,
  parameter int EXT_DIV = `T2_EXT_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // clock selects held in the shared clock select register
  input wire logic high_byte_fast_clock_select,
  input wire logic low_byte_fast_clock_select,
  // timer interrupt enable from the interrupt enable register
  input wire logic timer_irq_enable,
  // external oscillator
  input wire logic ext_osc,
  // interrupt request to the processor
  output logic timer_irq
);

  // control register fields
  logic high_overflow_flag_q;
  logic low_overflow_flag_q;
  logic low_overflow_irq_enable_q;
  logic split_mode_select_q;
  logic run_control_q;
  logic alternate_clock_select_q;

  // reload and count bytes
  logic [7:0] reload_low_byte_q;
  logic [7:0] reload_high_byte_q;
  logic [7:0] count_low_byte_q;
  logic [7:0] count_high_byte_q;
  logic [7:0] count_low_byte_d;
  logic [7:0] count_high_byte_d;

  // register decode strobes
  logic wr_ctrl;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;

  // timebase enables
  logic sys_div_tick;
  logic ext_div_tick;
  timer2_pkg::timebase_t low_src;
  timer2_pkg::timebase_t high_src;
  logic low_tick;
  logic high_tick;

  // per-byte advance and wrap events
  logic low_step;
  logic high_step;
  logic low_wrap;
  logic high_wrap;
  logic full_wrap;
  logic hovf_set;
  logic lovf_set;

  // read value and request
  logic [7:0] ctrl_view;
  logic [7:0] rdata_d;
  logic irq_d;

  // reset image as a vector, since a field cannot be picked out of a bare literal
  localparam logic [7:0] CTRL_RESET = `T2_CTRL_RESET;

  // enable pulses from the shared prescalers
  // [R12] synchronised external timebase
  timebase_gen #(
    .SYS_DIV(SYS_DIV),
    .EXT_DIV(EXT_DIV)
  ) u_timebase (
    .core_clk(core_clk),
    .reset(reset),
    .ext_osc(ext_osc),
    .sys_div_tick(sys_div_tick),
    .ext_div_tick(ext_div_tick)
  );

  // map a fast select and the alternate select onto a timebase
  function automatic timer2_pkg::timebase_t pick_src(
    input logic fast,
    input logic alt
  );
    if (fast)
      pick_src = timer2_pkg::SRC_SYS;
    else if (alt)
      pick_src = timer2_pkg::SRC_EXT_DIV8;
    else
      pick_src = timer2_pkg::SRC_SYS_DIV12;
  endfunction : pick_src

  // turn a chosen timebase into its enable pulse
  function automatic logic src_tick(
    input timer2_pkg::timebase_t src,
    input logic div12,
    input logic ext8
  );
    case (src)
      timer2_pkg::SRC_SYS: src_tick = 1'b1;
      timer2_pkg::SRC_EXT_DIV8: src_tick = ext8;
      timer2_pkg::SRC_SYS_DIV12: src_tick = div12;
      default: src_tick = 1'b0;
    endcase
  endfunction : src_tick

  // timebase per byte; the low select drives the whole 16-bit counter
  // [R11] alternate timebase choice
  // [R13] alternate select shared by both bytes
  // [R19] fast select overrides
  always_comb
  begin
    low_src = pick_src(low_byte_fast_clock_select, alternate_clock_select_q);
    high_src = pick_src(high_byte_fast_clock_select, alternate_clock_select_q);
    low_tick = src_tick(low_src, sys_div_tick, ext_div_tick);
    high_tick = src_tick(high_src, sys_div_tick, ext_div_tick);
  end

  // gating of each byte by mode and run control
  // [R9] run gates counting
  // [R10] split low byte free running
  // [R20] one step per enable pulse
  always_comb
  begin
    if (split_mode_select_q)
    begin
      low_step = low_tick;
      high_step = run_control_q & high_tick;
    end
    else
    begin
      low_step = run_control_q & low_tick;
      high_step = low_step & (count_low_byte_q == `T2_BYTE_MAX);
    end
  end

  // wrap detection; in 16-bit mode the high byte only moves on a carry
  // [R16] carry links the bytes only outside split
  assign low_wrap = low_step & (count_low_byte_q == `T2_BYTE_MAX);
  assign high_wrap = high_step & (count_high_byte_q == `T2_BYTE_MAX);
  assign full_wrap = ~split_mode_select_q & high_wrap;

  // flag set events
  // [R1] high byte wrap
  // [R2] whole count wrap
  assign hovf_set = high_wrap;
  // [R5] every low byte wrap
  assign lovf_set = low_wrap;

  // address decode for writes
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_rld_lo = 1'b0;
    wr_rld_hi = 1'b0;
    wr_cnt_lo = 1'b0;
    wr_cnt_hi = 1'b0;
    if (!sfr_wr)
      wr_ctrl = 1'b0;
    else if (sfr_addr == `T2_ADDR_CTRL)
      wr_ctrl = 1'b1;
    else if (sfr_addr == `T2_ADDR_RLD_LO)
      wr_rld_lo = 1'b1;
    else if (sfr_addr == `T2_ADDR_RLD_HI)
      wr_rld_hi = 1'b1;
    else if (sfr_addr == `T2_ADDR_CNT_LO)
      wr_cnt_lo = 1'b1;
    else if (sfr_addr == `T2_ADDR_CNT_HI)
      wr_cnt_hi = 1'b1;
  end

  // overflow flags: a wrap in the clearing cycle still sets the flag
  // [R4] only software clears the high flag
  always_ff @(posedge core_clk)
  begin
    if (reset)
      high_overflow_flag_q <= 1'b0;
    else if (hovf_set)
      high_overflow_flag_q <= 1'b1;
    else if (wr_ctrl)
      high_overflow_flag_q <= sfr_wdata[`T2_BIT_HOVF];
  end

  // [R5] low flag is never cleared by hardware
  always_ff @(posedge core_clk)
  begin
    if (reset)
      low_overflow_flag_q <= 1'b0;
    else if (lovf_set)
      low_overflow_flag_q <= 1'b1;
    else if (wr_ctrl)
      low_overflow_flag_q <= sfr_wdata[`T2_BIT_LOVF];
  end

  // writable control fields; bits 4 and 1 have no storage
  // [R8] split mode select
  // [R14] unused bits dropped
  // [R21] reset to stopped 16-bit mode
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      low_overflow_irq_enable_q <= CTRL_RESET[`T2_BIT_LIRQ_EN];
      split_mode_select_q <= CTRL_RESET[`T2_BIT_SPLIT];
      run_control_q <= CTRL_RESET[`T2_BIT_RUN];
      alternate_clock_select_q <= CTRL_RESET[`T2_BIT_XCLK];
    end
    else if (wr_ctrl)
    begin
      low_overflow_irq_enable_q <= sfr_wdata[`T2_BIT_LIRQ_EN];
      split_mode_select_q <= sfr_wdata[`T2_BIT_SPLIT];
      run_control_q <= sfr_wdata[`T2_BIT_RUN];
      alternate_clock_select_q <= sfr_wdata[`T2_BIT_XCLK];
    end
  end

  // reload bytes, software only
  // [R15] reload storage
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      reload_low_byte_q <= `T2_BYTE_RESET;
      reload_high_byte_q <= `T2_BYTE_RESET;
    end
    else
    begin
      if (wr_rld_lo)
        reload_low_byte_q <= sfr_wdata;
      if (wr_rld_hi)
        reload_high_byte_q <= sfr_wdata;
    end
  end

  // next low count; a software write beats a step in the same cycle
  // [R17] full wrap reloads the low byte too
  // [R18] split wrap reloads own byte
  always_comb
  begin
    count_low_byte_d = count_low_byte_q;
    if (wr_cnt_lo)
      count_low_byte_d = sfr_wdata;
    else if (full_wrap)
      count_low_byte_d = reload_low_byte_q;
    else if (split_mode_select_q && low_wrap)
      count_low_byte_d = reload_low_byte_q;
    else if (low_step)
      count_low_byte_d = count_low_byte_q + 8'h01;
  end

  // next high count; in 16-bit mode a low-only wrap leaves low at 00
  // [R17] full wrap loads the high reload
  // [R18] split high reload
  always_comb
  begin
    count_high_byte_d = count_high_byte_q;
    if (wr_cnt_hi)
      count_high_byte_d = sfr_wdata;
    else if (high_wrap)
      count_high_byte_d = reload_high_byte_q;
    else if (high_step)
      count_high_byte_d = count_high_byte_q + 8'h01;
  end

  // count storage
  // [R21] counts clear on reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      count_low_byte_q <= `T2_BYTE_RESET;
      count_high_byte_q <= `T2_BYTE_RESET;
    end
    else
    begin
      count_low_byte_q <= count_low_byte_d;
      count_high_byte_q <= count_high_byte_d;
    end
  end

  // control register as software sees it
  // [R14] unused bits read zero
  always_comb
  begin
    ctrl_view = 8'h00;
    ctrl_view[`T2_BIT_HOVF] = high_overflow_flag_q;
    ctrl_view[`T2_BIT_LOVF] = low_overflow_flag_q;
    ctrl_view[`T2_BIT_LIRQ_EN] = low_overflow_irq_enable_q;
    ctrl_view[`T2_BIT_SPLIT] = split_mode_select_q;
    ctrl_view[`T2_BIT_RUN] = run_control_q;
    ctrl_view[`T2_BIT_XCLK] = alternate_clock_select_q;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    if (sfr_addr == `T2_ADDR_CTRL)
      rdata_d = ctrl_view;
    else if (sfr_addr == `T2_ADDR_RLD_LO)
      rdata_d = reload_low_byte_q;
    else if (sfr_addr == `T2_ADDR_RLD_HI)
      rdata_d = reload_high_byte_q;
    else if (sfr_addr == `T2_ADDR_CNT_LO)
      rdata_d = count_low_byte_q;
    else if (sfr_addr == `T2_ADDR_CNT_HI)
      rdata_d = count_high_byte_q;
    else
      rdata_d = 8'h00;
  end

  // read data held until the next read
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= rdata_d;
  end

  // request level; stays up while any enabled flag stands
  // [R3] high flag request
  // [R6] low flag needs both enables
  assign irq_d = timer_irq_enable
    & (high_overflow_flag_q
    | (low_overflow_flag_q & low_overflow_irq_enable_q));

  // registered so the request never glitches on decode
  always_ff @(posedge core_clk)
  begin
    if (reset)
      timer_irq <= 1'b0;
    else
      timer_irq <= irq_d;
  end

endmodule : timer2_auto_reload

// [inc/timer2_defs.svh]
// register map, field positions, reset values and divider counts
`ifndef TIMER2_DEFS_SVH
`define TIMER2_DEFS_SVH
`define T2_ADDR_CTRL 8'hc8
`define T2_ADDR_RLD_LO 8'hca
`define T2_ADDR_RLD_HI 8'hcb
`define T2_ADDR_CNT_LO 8'hcc
`define T2_ADDR_CNT_HI 8'hcd
`define T2_BIT_HOVF 7
`define T2_BIT_LOVF 6
`define T2_BIT_LIRQ_EN 5
`define T2_BIT_SPLIT 3
`define T2_BIT_RUN 2
`define T2_BIT_XCLK 0
`define T2_CTRL_RESET 8'h00
`define T2_BYTE_RESET 8'h00
`define T2_BYTE_MAX 8'hff
`define T2_SYS_DIV 12
`define T2_EXT_DIV 8
`endif

// [inc/timer2_pkg.sv]
// types shared by the timer files
package timer2_pkg;
  // one-hot timebase choice for a count byte
  typedef enum logic [2:0]
  {
    SRC_SYS_DIV12 = 3'b001,
    SRC_EXT_DIV8 = 3'b010,
    SRC_SYS = 3'b100
  } timebase_t;
endpackage : timer2_pkg

// [hdl/timebase_gen.sv]
// divided system clock and synchronised external oscillator enables
`timescale 1ns/10ps
`include "timer2_defs.svh"
module timebase_gen #(
  parameter int SYS_DIV = `T2_SYS_DIV,
  parameter int EXT_DIV = `T2_EXT_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // external oscillator level
  input wire logic ext_osc,
  // one-cycle count enables
  output logic sys_div_tick,
  output logic ext_div_tick
);
  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic [SW-1:0] sys_cnt_q;
  logic [EW-1:0] ext_cnt_q;
  logic osc_meta_q;
  logic osc_sync_q;
  logic osc_prev_q;
  logic osc_rise;

  // system clock prescaler, pulse on the last count
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sys_cnt_q <= '0;
    else if (sys_cnt_q == SYS_LAST)
      sys_cnt_q <= '0;
    else
      sys_cnt_q <= sys_cnt_q + 1'b1;
  end

  assign sys_div_tick = (sys_cnt_q == SYS_LAST);

  // two-stage synchroniser; the edge detector only sees the second stage
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      osc_meta_q <= ext_osc;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end

  assign osc_rise = osc_sync_q & ~osc_prev_q;

  // count oscillator edges, pulse on every eighth
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ext_cnt_q <= '0;
    else if (osc_rise)
      ext_cnt_q <= (ext_cnt_q == EXT_LAST) ? '0 : ext_cnt_q + 1'b1;
  end

  assign ext_div_tick = osc_rise & (ext_cnt_q == EXT_LAST);
endmodule : timebase_gen

// [dv/timer2_checker.sv]
// port-level checks for the auto-reload timer
`timescale 1ns/10ps
`include "timer2_defs.svh"
module timer2_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // interrupt
  input wire logic timer_irq_enable,
  input wire logic timer_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // control read taken this cycle
  logic rd_ctl;
  assign rd_ctl = sfr_rd && sfr_addr == `T2_ADDR_CTRL;
  chk_reset_clears_outputs: assert property ($fell(reset) |-> sfr_rdata == 8'h00 && !timer_irq)
    else $error("outputs not clear after reset");
  chk_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  chk_unused_bits_zero: assert property (rd_ctl |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0)
    else $error("unused control bits read nonzero");
  chk_ctrl_field_readback: assert property (sfr_wr && sfr_addr == `T2_ADDR_CTRL ##1 !sfr_wr ##1 rd_ctl
    |=> (sfr_rdata & 8'h2d) == ($past(sfr_wdata, 3) & 8'h2d))
    else $error("control fields differ from last write");
  chk_reload_readback: assert property (sfr_wr && sfr_addr inside {8'hca, 8'hcb} ##1 !sfr_wr
    ##1 sfr_rd && sfr_addr == $past(sfr_addr, 2) |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("reload byte differs from last write");
  chk_high_flag_sticky: assert property (rd_ctl && !sfr_wr ##1 sfr_rdata[7] && !sfr_wr ##1 rd_ctl
    |=> sfr_rdata[7])
    else $error("high flag cleared without a write");
  chk_low_flag_sticky: assert property (rd_ctl && !sfr_wr ##1 sfr_rdata[6] && !sfr_wr ##1 rd_ctl
    |=> sfr_rdata[6])
    else $error("low flag cleared without a write");
  chk_irq_needs_enable: assert property (!timer_irq_enable |=> !timer_irq)
    else $error("interrupt without timer enable");
  chk_irq_flag_sources: assert property (rd_ctl && timer_irq_enable
    |=> timer_irq == (sfr_rdata[7] | (sfr_rdata[6] & sfr_rdata[5])))
    else $error("interrupt disagrees with flags");
  // main scenarios reached
  cover property (rd_ctl ##1 sfr_rdata[7]);
  cover property (rd_ctl ##1 sfr_rdata[6] && sfr_rdata[3]);
  cover property ($rose(timer_irq));
endmodule : timer2_checker

// [dv/tb.sv]
// self-checking bench for the auto-reload timer
`timescale 1ns/10ps
module tb;
  logic core_clk, reset, sfr_wr, sfr_rd, hi_fast, lo_fast, irq_en, ext_osc, timer_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  timer2_auto_reload dut (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .high_byte_fast_clock_select(hi_fast), .low_byte_fast_clock_select(lo_fast),
    .timer_irq_enable(irq_en), .ext_osc(ext_osc), .timer_irq(timer_irq));
  // system clock, 100 ns
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // external oscillator, slower than the system clock as it must be
  initial
  begin
    ext_osc = 1'b0;
    forever
    begin
      repeat (2) @(posedge core_clk);
      #1 ext_osc = ~ext_osc;
    end
  end
  // hang guard, about ten times the expected run
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    tests_run++;
    if ((v >= lo && v <= hi) !== 1'b1)
    begin
      fails++;
      $display("Error at %0t: got %h outside %h..%h", $time, v, lo, hi);
    end
  endtask : range
  task automatic check(input logic [7:0] v, input logic [7:0] exp);
    tests_run++;
    if (v !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, v, exp);
    end
  endtask : check
  // one write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1 sfr_wr = 1'b0;
  endtask : wr
  // one read, data registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #1 sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask : rd
  // reset values, one unmapped address among them
  task automatic t_reset();
    logic [7:0] a [6] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
    foreach (a[i])
    begin
      rd(a[i], d);
      check(d, 8'h00);
    end
  endtask : t_reset
  // every control bit written, unused ones stay zero
  task automatic t_ctrl();
    irq_en = 1'b1;
    wr(8'hc8, 8'hff);
    rd(8'hc8, d);
    check(d, 8'hed);
    check({7'h00, timer_irq}, 8'h01);
    irq_en = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check({7'h00, timer_irq}, 8'h00);
    wr(8'hc8, 8'h00);
    rd(8'hc8, d);
    check(d, 8'h00);
  endtask : t_ctrl
  // full 16-bit wrap with reload, then stop
  task automatic t_wrap16();
    lo_fast = 1'b1;
    irq_en = 1'b1;
    wr(8'hcb, 8'hff);
    wr(8'hca, 8'h80);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'hff);
    // low irq enable kept clear in 16-bit mode
    wr(8'hc8, 8'h04);
    repeat (300) @(posedge core_clk);
    rd(8'hc8, d);
    check(d, 8'hc4);
    rd(8'hc8, d);
    check(d, 8'hc4);
    check({7'h00, timer_irq}, 8'h01);
    rd(8'hcd, d);
    check(d, 8'hff);
    // low byte restarted from its reload byte, not from zero
    rd(8'hcc, d);
    range(d, 8'h80, 8'hff);
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h55);
    repeat (20) @(posedge core_clk);
    rd(8'hcc, d);
    check(d, 8'h55);
  endtask : t_wrap16
  // split mode: low byte free running, high byte gated by run
  task automatic t_split();
    hi_fast = 1'b1;
    wr(8'hca, 8'hf0);
    rd(8'hca, d);
    check(d, 8'hf0);
    wr(8'hcb, 8'h00);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h08);
    repeat (40) @(posedge core_clk);
    rd(8'hc8, d);
    check(d, 8'h48);
    check({7'h00, timer_irq}, 8'h00);
    rd(8'hcd, d);
    check(d, 8'h00);
    rd(8'hcc, d);
    range(d, 8'hf0, 8'hff);
    wr(8'hc8, 8'h28);
    repeat (40) @(posedge core_clk);
    rd(8'hc8, d);
    check(d, 8'h68);
    check({7'h00, timer_irq}, 8'h01);
    wr(8'hc8, 8'h0c);
    repeat (300) @(posedge core_clk);
    rd(8'hc8, d);
    check(d, 8'hcc);
  endtask : t_split
  // divided timebases: system over 12, external over 8, split
  task automatic t_timebase();
    logic [7:0] cfg [3] = '{8'h04, 8'h05, 8'h0d};
    logic [7:0] exp [3] = '{8'h20, 8'h0c, 8'h0c};
    logic [7:0] lo_seen;
    lo_fast = 1'b0;
    hi_fast = 1'b0;
    foreach (cfg[i])
    begin
      wr(8'hc8, 8'h00);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, cfg[i]);
      repeat (384) @(posedge core_clk);
      wr(8'hc8, 8'h00);
      rd(8'hcc, d);
      range(d, exp[i] - 8'h01, exp[i] + 8'h01);
      lo_seen = d;
      // split high byte shares the timebase; in 16-bit mode no carry reached it
      rd(8'hcd, d);
      check(d, cfg[i][3] ? lo_seen : 8'h00);
    end
  endtask : t_timebase
  // main sequence
  initial
  begin
    reset = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    hi_fast = 1'b0;
    lo_fast = 1'b0;
    irq_en = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    t_reset();
    t_ctrl();
    t_wrap16();
    t_split();
    t_timebase();
    test_done();
  end
endmodule : tb
bind timer2_auto_reload timer2_checker chk (.core_clk(core_clk), .reset(reset),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));
